// ---- asp_defs.svh ----
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
// register byte offsets
`define ASP_OFF_CONTROL 8'h00
`define ASP_OFF_BUFFER 8'h04
`define ASP_OFF_RATE 8'h08
// control field positions
`define ASP_CTL_RXDONE 0
`define ASP_CTL_TXDONE 1
`define ASP_CTL_RXNINTH 2
`define ASP_CTL_TXNINTH 3
`define ASP_CTL_RXEN 4
`define ASP_CTL_FILTER 5
`define ASP_CTL_MODE_LO 6
`define ASP_CTL_MODE_HI 7
// rate register field positions
`define ASP_RATE_DOUBLER 0
// reset values
`define ASP_CONTROL_RESET 8'h00
`define ASP_RX_PRELOAD 9'h1FF
// timing counts
`define ASP_OVERSAMPLE 16
`define ASP_FIXED_DIV_SLOW 64
`define ASP_FIXED_DIV_FAST 32
`define ASP_TIMER_DIV 32
`endif

// ---- asp_pkg.sv ----
package asp_pkg;
  typedef enum logic [1:0]
  {
    ASP_MODE_SHIFT = 2'b00,
    ASP_MODE_VAR10 = 2'b01,
    ASP_MODE_FIX11 = 2'b10,
    ASP_MODE_VAR11 = 2'b11
  } asp_mode_type;
  typedef struct packed
  {
    logic rx_done_flag;
    logic tx_done_flag;
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic multiproc_filter;
  } asp_flags_type;
endpackage

// ---- asp_tick_gen.sv ----
`timescale 1ns/10ps
`include "asp_defs.svh"
// produces the 16x oversample enable from the clock or baud timer overflow
module asp_tick_gen
  import asp_pkg::*;
#(
  parameter int CLK_PER_OSC = 1
)
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire asp_mode_type mode_in,
  input wire logic baud_doubler_in,
  input wire logic timer_ovf_in,
  output logic tick16_out
);
  logic [6:0] pre;
  logic [6:0] limit;
  logic src;
  logic [6:0] next_pre;
  // fixed mode: osc/64 or osc/32 baud -> 16x tick every 4 or 2 osc
  // variable: overflow/32 or /16 baud -> 16x tick every 2 or 1 overflows
  assign src = (mode_in == ASP_MODE_FIX11) ? 1'b1 : timer_ovf_in; // RQ13
  assign limit = (mode_in == ASP_MODE_FIX11) ?
    (baud_doubler_in ? 7'(`ASP_FIXED_DIV_FAST / `ASP_OVERSAMPLE - 1)
                     : 7'(`ASP_FIXED_DIV_SLOW / `ASP_OVERSAMPLE - 1)) : // RQ22
    (baud_doubler_in ? 7'(`ASP_TIMER_DIV / `ASP_OVERSAMPLE / 2 - 1)
                     : 7'(`ASP_TIMER_DIV / `ASP_OVERSAMPLE - 1)); // RQ21
  assign next_pre = (pre >= limit) ? 7'h00 : pre + 7'h01;
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      pre <= 7'h00;
    else if (src)
      pre <= next_pre;
  end
  assign tick16_out = src && (pre >= limit); // RQ24
endmodule

// ---- asp_serial_port.sv ----
`timescale 1ns/10ps
`include "asp_defs.svh"
//
// Summary of operation
// RQ1 - 10-bit mode: buffer write loads marker one
// RQ2 - transmit starts after next divide-by-16 rollover
// RQ3 - start bit, then data, then first shift
// RQ4 - 10-bit: zeros fill, done at tenth rollover
// RQ5 - receiver hunts falling edge at 16x rate
// RQ6 - falling edge resets counter, preloads all ones
// RQ7 - majority of samples seven, eight, nine
// RQ8 - start bit not zero restarts hunting
// RQ9 - 10-bit: nine-bit receive register, final shift
// RQ10 - 10-bit load gated by flag and filter
// RQ11 - always resume hunting; 11-bit after bit time
// RQ12 - 11-bit frame: start, eight, ninth, stop
// RQ13 - fixed rate osc/32 or /64, variable from timer
// RQ14 - 11-bit: buffer write copies transmit ninth bit
// RQ15 - 11-bit: stop inserted first, done at 11th
// RQ16 - 11-bit: nine-bit receive register, final shift
// RQ17 - 11-bit load gated by flag and filter
// RQ18 - 11-bit: stop bit value is ignored
// RQ19 - interrupt is OR of both done flags
// RQ20 - software flag writes act like hardware
// RQ21 - variable rate is overflow/32, doubled optionally
// RQ22 - fixed rate osc/64, or /32 when doubled
// RQ23 - master marks address bytes with ninth one
// RQ24 - counter advances on 16x rate enable
module asp_serial_port
  import asp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic timer_ovf_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic serial_irq_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  asp_flags_type flags;
  asp_mode_type mode;
  logic rx_enable;
  logic baud_doubler;
  logic [7:0] serial_buffer;
  logic tick16;
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  logic wr_ctl;
  logic wr_buf;
  logic wr_rate;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_word;
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `ASP_OFF_CONTROL) || (a == `ASP_OFF_BUFFER) || (a == `ASP_OFF_RATE);
  endfunction
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = addr_known(aw_addr);
  assign wr_ctl = do_write && w_lane0 && (aw_addr == `ASP_OFF_CONTROL);
  assign wr_buf = do_write && w_lane0 && (aw_addr == `ASP_OFF_BUFFER);
  assign wr_rate = do_write && w_lane0 && (aw_addr == `ASP_OFF_RATE);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_ok = addr_known(s_axi_araddr);
  assign rd_word =
    (s_axi_araddr == `ASP_OFF_CONTROL) ? {24'h000000, mode, flags.multiproc_filter, rx_enable,
      flags.tx_ninth_bit, flags.rx_ninth_bit, flags.tx_done_flag, flags.rx_done_flag} :
    (s_axi_araddr == `ASP_OFF_BUFFER) ? {24'h000000, serial_buffer} :
    (s_axi_araddr == `ASP_OFF_RATE) ? {31'h00000000, baud_doubler} : 32'h00000000;
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // ----------------------------------------
  // rate enable
  // ----------------------------------------
  asp_tick_gen u_tick
  (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .mode_in(mode),
    .baud_doubler_in(baud_doubler),
    .timer_ovf_in(timer_ovf_in),
    .tick16_out(tick16)
  );
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [3:0] tx_div;
  logic tx_roll;
  logic tx_pending;
  logic tx_send;
  logic tx_data_on;
  logic tx_stop_in;
  logic [8:0] tx_shift;
  logic tx_last;
  logic tx_done_set;
  logic is_eleven;
  assign is_eleven = mode[1];
  assign tx_roll = tick16 && (tx_div == 4'hF); // RQ24
  // 10-bit: marker beside MSB; 11-bit: stop beside ninth bit, rest zero
  assign tx_last = tx_data_on && tx_roll && (tx_shift[8:1] == 8'h01) && !tx_stop_in; // RQ4 RQ15
  assign tx_done_set = tx_last;
  assign txd_out = !tx_send ? 1'b1 : (tx_data_on ? tx_shift[0] : 1'b0); // RQ3
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      tx_div <= 4'h0;
    else if (tick16)
      tx_div <= tx_div + 4'h1;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      tx_pending <= 1'b0;
      tx_send <= 1'b0;
      tx_data_on <= 1'b0;
      tx_stop_in <= 1'b0;
      tx_shift <= 9'h1FF;
    end
    else if (wr_buf && mode != ASP_MODE_SHIFT)
    begin
      // 10-bit loads a marker one, 11-bit loads the ninth data bit
      tx_shift <= {is_eleven ? flags.tx_ninth_bit : 1'b1, w_data[7:0]}; // RQ1 RQ14
      tx_pending <= 1'b1;
      tx_send <= 1'b0;
      tx_data_on <= 1'b0;
      tx_stop_in <= is_eleven;
    end
    else if (tx_roll)
    begin
      if (tx_pending)
      begin
        tx_pending <= 1'b0;
        tx_send <= 1'b1; // RQ2
      end
      else if (tx_send && !tx_data_on)
        tx_data_on <= 1'b1; // RQ3
      else if (tx_last)
      begin
        tx_send <= 1'b0;
        tx_data_on <= 1'b0;
        tx_shift <= {1'b0, tx_shift[8:1]};
      end
      else if (tx_data_on)
      begin
        // first 11-bit shift inserts the stop bit, then zeros
        tx_shift <= {tx_stop_in, tx_shift[8:1]}; // RQ4 RQ15 RQ12
        tx_stop_in <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [3:0] rx_div;
  logic rx_busy;
  logic rx_prev;
  logic [2:0] rx_samp;
  logic rx_major;
  logic rx_first;
  logic [8:0] rx_shift;
  logic rx_tail;
  logic rx_start_edge;
  logic rx_bit_end;
  logic rx_final;
  logic rx_accept;
  logic rx_done_set;
  assign rx_start_edge = tick16 && !rx_busy && rx_enable && rx_prev && !rxd_in; // RQ5
  assign rx_bit_end = tick16 && rx_busy && (rx_div == 4'hF);
  assign rx_major = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_samp[2])
    | (rx_samp[1] & rx_samp[2]); // RQ7
  assign rx_final = rx_bit_end && !rx_first && !rx_tail && !rx_shift[0]; // RQ9 RQ16
  // 10-bit tests the stop bit, 11-bit the ninth bit; 11-bit stop ignored
  assign rx_accept = !flags.rx_done_flag && (!flags.multiproc_filter || rx_major); // RQ10 RQ17 RQ18
  assign rx_done_set = rx_final && rx_accept;
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      rx_div <= 4'h0;
      rx_busy <= 1'b0;
      rx_prev <= 1'b1;
      rx_samp <= 3'h7;
      rx_first <= 1'b0;
      rx_tail <= 1'b0;
      rx_shift <= `ASP_RX_PRELOAD;
    end
    else if (tick16)
    begin
      rx_prev <= rxd_in;
      if (rx_start_edge)
      begin
        rx_busy <= 1'b1;
        rx_div <= 4'h0; // RQ6
        rx_shift <= `ASP_RX_PRELOAD; // RQ6
        rx_first <= 1'b1;
        rx_tail <= 1'b0;
      end
      else if (rx_busy)
      begin
        rx_div <= rx_div + 4'h1;
        if (rx_div >= 4'h6 && rx_div <= 4'h8)
          rx_samp <= {rx_samp[1:0], rxd_in}; // RQ7
        if (rx_div == 4'hF)
        begin
          if (rx_first && rx_major)
            rx_busy <= 1'b0; // RQ8
          else if (rx_tail)
            rx_busy <= 1'b0; // RQ11
          else if (rx_final)
          begin
            rx_shift <= {rx_major, rx_shift[8:1]};
            rx_tail <= is_eleven;
            rx_busy <= is_eleven; // RQ11
          end
          else
            rx_shift <= {rx_major, rx_shift[8:1]}; // RQ8
          rx_first <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // flags and buffer
  // ----------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      flags <= asp_flags_type'(5'h00);
      mode <= ASP_MODE_SHIFT;
      rx_enable <= 1'b0;
      baud_doubler <= 1'b0; // RQ22
      serial_buffer <= 8'h00;
    end
    else
    begin
      if (wr_ctl)
      begin
        flags.rx_done_flag <= w_data[`ASP_CTL_RXDONE]; // RQ20
        flags.tx_done_flag <= w_data[`ASP_CTL_TXDONE]; // RQ20
        flags.rx_ninth_bit <= w_data[`ASP_CTL_RXNINTH];
        flags.tx_ninth_bit <= w_data[`ASP_CTL_TXNINTH];
        rx_enable <= w_data[`ASP_CTL_RXEN];
        flags.multiproc_filter <= w_data[`ASP_CTL_FILTER];
        mode <= asp_mode_type'(w_data[`ASP_CTL_MODE_HI:`ASP_CTL_MODE_LO]);
      end
      if (wr_rate)
        baud_doubler <= w_data[`ASP_RATE_DOUBLER];
      // hardware sets win over a same-cycle clear; never cleared here
      if (tx_done_set)
        flags.tx_done_flag <= 1'b1; // RQ4 RQ15 RQ19
      if (rx_done_set)
      begin
        flags.rx_done_flag <= 1'b1; // RQ10 RQ17
        flags.rx_ninth_bit <= rx_major; // RQ10 RQ17
        serial_buffer <= rx_shift[8:1]; // RQ10 RQ17 RQ12
      end
    end
  end
  assign serial_irq_out = flags.rx_done_flag | flags.tx_done_flag; // RQ19 RQ20
  // ----------------------------------------
  // checks
  // ----------------------------------------
  irq_or_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    serial_irq_out == (flags.rx_done_flag || flags.tx_done_flag)) // RQ19
    else $error("irq not OR of flags");
  tx_done_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    flags.tx_done_flag && !wr_ctl |=> flags.tx_done_flag) // RQ19
    else $error("tx done cleared by hardware");
  rx_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    rx_final && flags.rx_done_flag && !wr_ctl |=> $stable(serial_buffer)) // RQ10
    else $error("buffer loaded while rx done set");
  rx_load_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    rx_done_set |=> flags.rx_done_flag && flags.rx_ninth_bit == $past(rx_major)) // RQ17
    else $error("rx load wrong");
  rx_preload_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    rx_start_edge |=> rx_shift == 9'h1FF && rx_div == 4'h0) // RQ6
    else $error("rx preload missing");
  start_reject_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    rx_bit_end && rx_first && rx_major |=> !rx_busy) // RQ8
    else $error("bad start not rejected");
  tx_start_low_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    tx_roll && tx_pending && !wr_buf |=> !txd_out && tx_send) // RQ2
    else $error("start bit not driven");
  tx_idle_high_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !tx_send |-> txd_out) // RQ3
    else $error("idle line not high");
  tx_end_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    tx_last && !wr_buf |=> !tx_send && flags.tx_done_flag) // RQ4
    else $error("tx end wrong");
endmodule

// ---- asp_remote_node.sv ----
`timescale 1ns/10ps
// -----------------------------------------
// remote serial node on the far side
// -----------------------------------------
module asp_remote_node
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] bit_clks_in,
  input wire logic long_frame_in,
  input wire logic send_in,
  input wire logic [9:0] send_word_in,
  input wire logic glitch_in,
  input wire logic line_in,
  output logic line_out,
  output logic busy_out,
  output logic got_out,
  output logic [9:0] got_word_out
);
  logic [9:0] tx_word;
  logic [9:0] rx_word;
  int nb;
  assign nb = long_frame_in ? 10 : 9;
  initial
  begin
    line_out = 1'h1;
    busy_out = 1'h0;
    got_out = 1'h0;
    got_word_out = 10'h000;
  end
  // sender: start bit, then data lsb first, ninth bit (long frame only), stop
  always @(posedge ref_clk_in)
  begin
    if (glitch_in)
    begin
      line_out <= 1'h0;
      repeat (8) @(posedge ref_clk_in);
      line_out <= 1'h1;
    end
    else if (send_in)
    begin
      busy_out <= 1'h1;
      tx_word = send_word_in;
      line_out <= 1'h0;
      for (int i = 0; i < nb; i++)
      begin
        repeat (bit_clks_in) @(posedge ref_clk_in);
        line_out <= tx_word[i];
      end
      repeat (bit_clks_in) @(posedge ref_clk_in);
      line_out <= 1'h1;
      busy_out <= 1'h0;
    end
  end
  // receiver: samples each bit in its middle
  always @(posedge ref_clk_in)
  begin
    if (!reset_in && line_in === 1'h0)
    begin
      rx_word = 10'h000;
      repeat (bit_clks_in / 2) @(posedge ref_clk_in);
      for (int j = 0; j < nb; j++)
      begin
        repeat (bit_clks_in) @(posedge ref_clk_in);
        rx_word[j] = line_in;
      end
      got_word_out <= rx_word;
      got_out <= 1'h1;
      @(posedge ref_clk_in);
      got_out <= 1'h0;
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
`include "asp_defs.svh"
module testbench
  import asp_pkg::*;
;
  logic ref_clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic timer_ovf_in = 1'h0;
  logic rxd_in, txd_out, serial_irq_out, busy, got, glitch = 1'h0, send = 1'h0, lng = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, bit_clks = 8'h20, ctl, d;
  logic [31:0] wdata = 32'h0, rdata, r, seed = 32'hFB98162C;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, n9, stp;
  logic [1:0] bresp, rresp;
  logic [9:0] send_word = 10'h3FF, got_word;
  logic [33:0] res_q[$];
  logic [9:0] tx_q[$];
  logic [1:0] sigs;
  logic [3:0] cfg_dbl = 4'h5;
  asp_mode_type cfg_mode [4] = '{ASP_MODE_FIX11, ASP_MODE_FIX11, ASP_MODE_VAR11, ASP_MODE_VAR10};
  int fails = 0, check_count = 0;
  assign sigs = {busy, serial_irq_out};
  always #2.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) timer_ovf_in <= ~timer_ovf_in;
  asp_serial_port dut
  (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .timer_ovf_in(timer_ovf_in),
    .rxd_in(rxd_in), .txd_out(txd_out), .serial_irq_out(serial_irq_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  asp_remote_node node
  (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .bit_clks_in(bit_clks),
    .long_frame_in(lng), .send_in(send), .send_word_in(send_word), .glitch_in(glitch),
    .line_in(txd_out), .line_out(rxd_in), .busy_out(busy), .got_out(got), .got_word_out(got_word)
  );
  // -----------------------------------------
  // helpers and bus tasks
  // -----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic test_done();
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic expire(input int n, input int lim);
    if (n >= lim)
    begin
      check("wait", 34'h0, 34'h1);
      test_done();
    end
  endtask
  task automatic wait_sig(input int k, input logic lvl);
    int n;
    n = 0;
    while (sigs[k] !== lvl && n < 4000)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    expire(n, 4000);
  endtask
  task automatic irq_is(input logic v);
    @(posedge ref_clk_in);
    check("irq", {33'h0, v}, {33'h0, serial_irq_out});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] resp);
    int n;
    @(posedge ref_clk_in);
    res_q.push_back({resp, 32'h0});
    r = rnd();
    awaddr <= a;
    wdata <= {r[31:8], v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      n++;
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (!bvalid && n < 100);
    bready <= 1'h0;
    expire(n, 100);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] resp);
    int n;
    @(posedge ref_clk_in);
    res_q.push_back({resp, 24'h0, v});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      n++;
      if (arready)
        arvalid <= 1'h0;
    end
    while (!rvalid && n < 100);
    rready <= 1'h0;
    expire(n, 100);
  endtask
  task automatic send_frame(input logic [9:0] w);
    @(posedge ref_clk_in);
    send_word <= w;
    send <= 1'h1;
    @(posedge ref_clk_in);
    send <= 1'h0;
    @(posedge ref_clk_in);
    wait_sig(1, 1'h0);
  endtask
  always @(posedge ref_clk_in)
  begin
    if (bvalid && bready)
      check("bresp", res_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready)
      check("read", res_q.pop_front(), {rresp, rdata});
    if (got)
      check("frame", {24'h0, tx_q.pop_front()}, {24'h0, got_word});
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk_in);
    check("run", 34'h0, 34'h1);
    test_done();
  end
  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'h0;
    rd(`ASP_OFF_CONTROL, `ASP_CONTROL_RESET, 2'h0);
    rd(`ASP_OFF_RATE, 8'h00, 2'h0);
    rd(8'h0C, 8'h00, 2'h2);
    wr(8'h0C, 8'hFF, 2'h2);
    wr(`ASP_OFF_CONTROL, 8'h01, 2'h0);
    irq_is(1'h1);
    wr(`ASP_OFF_CONTROL, 8'h00, 2'h0);
    irq_is(1'h0);
    for (int c = 0; c < 4; c++)
    begin
      r = rnd();
      d = r[7:0];
      n9 = r[8];
      stp = r[9];
      lng = (cfg_mode[c] != ASP_MODE_VAR10);
      bit_clks <= cfg_dbl[c] ? 8'h20 : 8'h40;
      ctl = {cfg_mode[c], 2'h1, n9, 3'h0};
      wr(`ASP_OFF_RATE, {7'h0, cfg_dbl[c]}, 2'h0);
      wr(`ASP_OFF_CONTROL, ctl, 2'h0);
      tx_q.push_back(lng ? {1'h1, n9, d} : {2'h1, d});
      wr(`ASP_OFF_BUFFER, d, 2'h0);
      wait_sig(0, 1'h1);
      rd(`ASP_OFF_CONTROL, ctl | 8'h02, 2'h0);
      wr(`ASP_OFF_CONTROL, ctl, 2'h0);
      irq_is(1'h0);
      glitch <= 1'h1;
      @(posedge ref_clk_in);
      glitch <= 1'h0;
      repeat (128) @(posedge ref_clk_in);
      send_frame(lng ? {stp, n9, d} : {2'h1, d});
      wait_sig(0, 1'h1);
      rd(`ASP_OFF_BUFFER, d, 2'h0);
      rd(`ASP_OFF_CONTROL, ctl | {5'h0, lng ? n9 : 1'h1, 2'h1}, 2'h0);
      ctl = ctl | 8'h20;
      wr(`ASP_OFF_CONTROL, ctl, 2'h0);
      send_frame(lng ? {2'h2, ~d} : {2'h0, ~d});
      repeat (64) @(posedge ref_clk_in);
      rd(`ASP_OFF_CONTROL, ctl, 2'h0);
      send_frame(lng ? {2'h3, ~d} : {2'h1, ~d});
      wait_sig(0, 1'h1);
      send_frame(lng ? {2'h3, d} : {2'h1, d});
      rd(`ASP_OFF_BUFFER, ~d, 2'h0);
      rd(`ASP_OFF_CONTROL, ctl | 8'h05, 2'h0);
    end
    repeat (4) @(posedge ref_clk_in);
    check("left", 34'h0, 34'(res_q.size() + tx_q.size()));
    test_done();
  end
endmodule
